// ### logic/erase_protect_ctrl.sv
`timescale 1ns/1ns
`default_nettype none


module erase_protect_ctrl #(
  parameter int block_erase_cycles = flash_cmd_pkg::block_erase_cycles,
  parameter int chip_erase_cycles = flash_cmd_pkg::chip_erase_cycles
) (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // serial link
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  // control and array feedback
  input wire logic protection_lock_bit,
  input wire logic array_verify_fail,
  // status
  output logic write_enable_latch_r,
  output logic busy_r,
  output logic erase_program_error_flag_r,
  output logic [31:0] sector_prot_r,
  // array erase request and sequential program exit
  output logic erase_go_r,
  output logic [23:0] erase_first_addr_r,
  output logic [23:0] erase_last_addr_r,
  output logic [7:0] erase_fill_r,
  output logic seq_prog_exit_r
);

  frame_if fr ();

  spi_frame_shifter u_shifter (
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi),
    .fr(fr)
  );

  // ---------------------------------------------------------------
  // chip select synchroniser and frame end
  // ---------------------------------------------------------------
  logic cs_meta_r;
  logic cs_sync_r;
  logic cs_prev_r;
  logic tgl_seen_r;
  logic tgl_load_r;
  logic frame_end;

  // two flops before anything looks at the pin
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cs_meta_r <= 1'b1;
      cs_sync_r <= 1'b1;
      cs_prev_r <= 1'b1;
    end else begin
      cs_meta_r <= spi_cs_n;
      cs_sync_r <= cs_meta_r;
      cs_prev_r <= cs_sync_r;
    end
  end

  assign frame_end = cs_sync_r && !cs_prev_r;

  // a frame with no clock edges leaves the toggle alone and is dropped;
  // reset does not reach the link side, so its parity is copied once, on the first cycle after reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tgl_seen_r <= 1'b0;
      tgl_load_r <= 1'b1;
    end else if (tgl_load_r) begin
      tgl_seen_r <= fr.frame_tgl;
      tgl_load_r <= 1'b0;
    end else if (frame_end) begin
      tgl_seen_r <= fr.frame_tgl;
    end
  end

  // ---------------------------------------------------------------
  // command decode at frame end
  // ---------------------------------------------------------------
  logic done;
  logic whole;
  logic addr_ok;
  logic [4:0] sec_idx;
  logic sec_locked;
  logic wel_set;
  logic wel_clr;
  logic start_erase;
  logic start_chip;
  logic prot_set;
  logic seq_exit;
  logic [23:0] span;

  // frame data is stable here: the last serial edge came before cs rose
  assign done = frame_end && (fr.frame_tgl != tgl_seen_r) && !busy_r;
  assign whole = (fr.bit_phase == 3'h0) && (fr.nbytes != 3'h0);
  assign addr_ok = whole && (fr.nbytes == flash_cmd_pkg::frame_bytes_addr);
  assign sec_idx = fr.addr[flash_cmd_pkg::sector_msb:flash_cmd_pkg::sector_lsb];
  assign sec_locked = sector_prot_r[sec_idx];

  always_comb begin
    wel_set = 1'b0;
    wel_clr = 1'b0;
    start_erase = 1'b0;
    start_chip = 1'b0;
    prot_set = 1'b0;
    seq_exit = 1'b0;
    span = flash_cmd_pkg::span_chip;
    if (done) begin
      case (fr.opcode)
        flash_cmd_pkg::op_write_enable: begin
          wel_set = whole;
        end
        flash_cmd_pkg::op_write_disable: begin
          wel_clr = whole;
          seq_exit = whole;
        end
        flash_cmd_pkg::op_erase_4k, flash_cmd_pkg::op_erase_32k,
        flash_cmd_pkg::op_erase_64k: begin
          // every block size lies inside one 64 Kbyte sector
          if (write_enable_latch_r) begin
            if (!addr_ok || sec_locked) begin
              wel_clr = 1'b1;
            end else begin
              start_erase = 1'b1;
            end
          end
          case (fr.opcode)
            flash_cmd_pkg::op_erase_4k: span = flash_cmd_pkg::span_4k;
            flash_cmd_pkg::op_erase_32k: span = flash_cmd_pkg::span_32k;
            default: span = flash_cmd_pkg::span_64k;
          endcase
        end
        flash_cmd_pkg::op_chip_erase_a, flash_cmd_pkg::op_chip_erase_b: begin
          if (write_enable_latch_r && whole) begin
            if (|sector_prot_r) begin
              wel_clr = 1'b1;
            end else begin
              start_erase = 1'b1;
              start_chip = 1'b1;
            end
          end
        end
        flash_cmd_pkg::op_protect_sector: begin
          if (write_enable_latch_r) begin
            wel_clr = 1'b1;
            prot_set = addr_ok && !protection_lock_bit;
          end
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // write enable latch
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      write_enable_latch_r <= 1'b0;
    end else if (start_erase || wel_clr) begin
      // dropped at erase start, well before the erase finishes
      write_enable_latch_r <= 1'b0;
    end else if (wel_set) begin
      write_enable_latch_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      seq_prog_exit_r <= 1'b0;
    end else begin
      seq_prog_exit_r <= seq_exit;
    end
  end

  // ---------------------------------------------------------------
  // sector protection bits
  // ---------------------------------------------------------------
  for (genvar s = 0; s < flash_cmd_pkg::sector_count; s++) begin : g_prot
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        sector_prot_r[s] <= flash_cmd_pkg::sector_prot_reset[s];
      end else if (prot_set && sec_idx == 5'(s)) begin
        sector_prot_r[s] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // self-timed erase engine
  // ---------------------------------------------------------------
  flash_cmd_pkg::ctrl_state_type state_r;
  logic [31:0] timer_r;

  // the array is not modelled: it receives the range and fill pattern
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= flash_cmd_pkg::st_idle;
      busy_r <= 1'b0;
      timer_r <= 32'h00000000;
      erase_go_r <= 1'b0;
      erase_first_addr_r <= 24'h000000;
      erase_last_addr_r <= 24'h000000;
      erase_fill_r <= flash_cmd_pkg::erased_byte;
    end else begin
      erase_go_r <= 1'b0;
      case (state_r)
        flash_cmd_pkg::st_idle: begin
          if (start_erase) begin
            state_r <= flash_cmd_pkg::st_erase;
            busy_r <= 1'b1;
            erase_go_r <= 1'b1;
            erase_fill_r <= flash_cmd_pkg::erased_byte;
            erase_first_addr_r <= fr.addr & ~span;
            erase_last_addr_r <= fr.addr | span;
            timer_r <= start_chip ? 32'(chip_erase_cycles - 1) :
                                    32'(block_erase_cycles - 1);
          end
        end
        flash_cmd_pkg::st_erase: begin
          if (timer_r == 32'h00000000) begin
            state_r <= flash_cmd_pkg::st_idle;
            busy_r <= 1'b0;
          end else begin
            timer_r <= timer_r - 32'h00000001;
          end
        end
        default: begin
          state_r <= flash_cmd_pkg::st_idle;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  // sticky until the next erase begins; failures only count while busy
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      erase_program_error_flag_r <= 1'b0;
    end else if (busy_r && array_verify_fail) begin
      erase_program_error_flag_r <= 1'b1;
    end else if (start_erase) begin
      erase_program_error_flag_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic is_block;
  logic is_chip;
  assign is_block = (fr.opcode == flash_cmd_pkg::op_erase_4k) ||
                    (fr.opcode == flash_cmd_pkg::op_erase_32k) ||
                    (fr.opcode == flash_cmd_pkg::op_erase_64k);
  assign is_chip = (fr.opcode == flash_cmd_pkg::op_chip_erase_a) ||
                   (fr.opcode == flash_cmd_pkg::op_chip_erase_b);

  sequence blk_cmd_s;
    done && is_block && write_enable_latch_r;
  endsequence

  sequence refused_s;
    !busy_r && !write_enable_latch_r && !erase_go_r;
  endsequence

  sequence go_4k_s;
    erase_go_r && erase_first_addr_r[11:0] == 12'h000 &&
      erase_last_addr_r[11:0] == 12'hFFF;
  endsequence

  wren_sets_latch_a: assert property (
    done && fr.opcode == flash_cmd_pkg::op_write_enable && whole
      |=> write_enable_latch_r)
    else $error("write enable did not set latch");

  wren_partial_keeps_a: assert property (
    done && fr.opcode == flash_cmd_pkg::op_write_enable && !whole
      |=> $stable(write_enable_latch_r))
    else $error("partial write enable changed latch");

  wrdis_clears_latch_a: assert property (
    done && fr.opcode == flash_cmd_pkg::op_write_disable && whole
      |=> !write_enable_latch_r && seq_prog_exit_r)
    else $error("write disable did not clear latch");

  erase_needs_latch_a: assert property (
    $rose(busy_r) |-> $past(write_enable_latch_r))
    else $error("erase started without latch");

  blk_short_abort_a: assert property (
    blk_cmd_s and (!addr_ok) |=> refused_s)
    else $error("incomplete block erase not aborted");

  blk_protected_refused_a: assert property (
    blk_cmd_s and (addr_ok && sec_locked) |=> refused_s)
    else $error("block erase of protected sector ran");

  blk_4k_mask_a: assert property (
    blk_cmd_s and (addr_ok && !sec_locked && fr.opcode == flash_cmd_pkg::op_erase_4k)
      |=> go_4k_s)
    else $error("4k erase range wrong");

  chip_full_range_a: assert property (
    done && is_chip && write_enable_latch_r && whole && !(|sector_prot_r)
      |=> erase_go_r && erase_first_addr_r == 24'h000000 &&
          erase_last_addr_r == flash_cmd_pkg::span_chip)
    else $error("chip erase range wrong");

  chip_protected_a: assert property (
    done && is_chip && write_enable_latch_r && whole && (|sector_prot_r)
      |=> refused_s)
    else $error("chip erase with protection ran");

  busy_no_latch_a: assert property (
    busy_r |-> !write_enable_latch_r)
    else $error("latch still set during erase");

  fill_all_ones_a: assert property (
    erase_go_r |-> erase_fill_r == 8'hFF ##1 busy_r)
    else $error("erase fill not all ones");

  fail_sets_flag_a: assert property (
    busy_r && array_verify_fail |=> erase_program_error_flag_r)
    else $error("erase failure not flagged");

  protect_sets_bit_a: assert property (
    done && fr.opcode == flash_cmd_pkg::op_protect_sector && write_enable_latch_r &&
      addr_ok && !protection_lock_bit
      |=> sector_prot_r[$past(sec_idx)] && !write_enable_latch_r)
    else $error("protect sector did not set bit");

  protect_locked_a: assert property (
    done && fr.opcode == flash_cmd_pkg::op_protect_sector && write_enable_latch_r &&
      (protection_lock_bit || !addr_ok)
      |=> $stable(sector_prot_r) && !write_enable_latch_r)
    else $error("locked or partial protect changed bits");

  prot_reset_ones_a: assert property (
    $past(!rst_n) |-> sector_prot_r == flash_cmd_pkg::sector_prot_reset)
    else $error("protection bits not all one after reset");

endmodule

`default_nettype wire

// ### common/flash_cmd_pkg.sv
package flash_cmd_pkg;

  // ---------------------------------------------------------------
  // command opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] op_erase_4k = 8'h20;
  localparam logic [7:0] op_erase_32k = 8'h52;
  localparam logic [7:0] op_erase_64k = 8'hD8;
  localparam logic [7:0] op_chip_erase_a = 8'h60;
  localparam logic [7:0] op_chip_erase_b = 8'hC7;
  localparam logic [7:0] op_write_enable = 8'h06;
  localparam logic [7:0] op_write_disable = 8'h04;
  localparam logic [7:0] op_protect_sector = 8'h36;

  // ---------------------------------------------------------------
  // frame and address layout
  // ---------------------------------------------------------------
  localparam logic [2:0] frame_bytes_addr = 3'h4;
  localparam logic [2:0] frame_bytes_max = 3'h4;
  localparam logic [2:0] bit_last = 3'h7;
  localparam int sector_count = 32;
  localparam int sector_lsb = 16;
  localparam int sector_msb = 20;
  // low address bits that each block size disregards
  localparam logic [23:0] span_4k = 24'h000FFF;
  localparam logic [23:0] span_32k = 24'h007FFF;
  localparam logic [23:0] span_64k = 24'h00FFFF;
  localparam logic [23:0] span_chip = 24'hFFFFFF;

  // ---------------------------------------------------------------
  // reset values and fill pattern
  // ---------------------------------------------------------------
  localparam logic [31:0] sector_prot_reset = 32'hFFFFFFFF;
  localparam logic [7:0] erased_byte = 8'hFF;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int clk_sys_mhz = 125;
  localparam int block_erase_time_us = 50;
  localparam int chip_erase_time_us = 2000;
  localparam int block_erase_cycles = block_erase_time_us * clk_sys_mhz;
  localparam int chip_erase_cycles = chip_erase_time_us * clk_sys_mhz;

  typedef enum logic {st_idle, st_erase} ctrl_state_type;

endpackage

// ### common/frame_if.sv
`timescale 1ns/1ns
`default_nettype none

// one captured spi frame, written on the serial clock and read by the
// system clock only after chip select has been seen high through a sync
interface frame_if;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic [2:0] nbytes;
  logic [2:0] bit_phase;
  logic frame_tgl;

  modport link (output opcode, addr, nbytes, bit_phase, frame_tgl);
  modport core (input opcode, addr, nbytes, bit_phase, frame_tgl);
endinterface

`default_nettype wire

// ### logic/spi_frame_shifter.sv
`timescale 1ns/1ns
`default_nettype none

module spi_frame_shifter (
  // serial pins
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  // captured frame
  frame_if.link fr
);

  logic fresh_r;
  logic [6:0] shift_r;
  logic [2:0] phase_r;
  logic [2:0] nbytes_r;
  logic [7:0] opcode_r;
  logic [23:0] addr_r;
  logic tgl_r = 1'b0; // power-up value: the link side has no reset
  logic [7:0] byte_full;
  logic byte_done;

  // ---------------------------------------------------------------
  // frame start marker
  // ---------------------------------------------------------------
  // preset by chip select high: the clock stands still between frames
  always_ff @(posedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  assign byte_full = {shift_r, spi_sdi};
  assign byte_done = !fresh_r && (phase_r == flash_cmd_pkg::bit_last);

  // ---------------------------------------------------------------
  // bit shifting, msb first on rising edges
  // ---------------------------------------------------------------
  // nothing here is cleared at frame end, so the values hold still for
  // the system side to read after chip select rises
  always_ff @(posedge spi_sck) begin
    if (fresh_r) begin
      phase_r <= 3'h1;
      shift_r <= {6'h00, spi_sdi};
      nbytes_r <= 3'h0;
      tgl_r <= !tgl_r;
    end else begin
      phase_r <= phase_r + 3'h1;
      shift_r <= byte_full[6:0];
      // counting stops at four, later bytes are ignored
      if (byte_done && nbytes_r != flash_cmd_pkg::frame_bytes_max) begin
        nbytes_r <= nbytes_r + 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // opcode and address bytes
  // ---------------------------------------------------------------
  always_ff @(posedge spi_sck) begin
    if (byte_done) begin
      case (nbytes_r)
        3'h0: opcode_r <= byte_full;
        3'h1: addr_r[23:16] <= byte_full;
        3'h2: addr_r[15:8] <= byte_full;
        3'h3: addr_r[7:0] <= byte_full;
        default: ;
      endcase
    end
  end

  assign fr.opcode = opcode_r;
  assign fr.addr = addr_r;
  assign fr.nbytes = nbytes_r;
  assign fr.bit_phase = phase_r;
  assign fr.frame_tgl = tgl_r;

endmodule

`default_nettype wire

// ### dv/spi_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------
// spi host, mode 0: the serial clock only runs inside a frame
// ---------------------------------------------------------------
module spi_host_model (
  // serial pins
  output var logic spi_sck,
  output var logic spi_cs_n,
  output var logic spi_sdi
);
  // idle: deselected, clock low
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
  end

  // shift the first nbits of a left-aligned frame, msb first, 80 ns per bit
  task automatic send(input logic [39:0] frame, input int nbits);
    begin
      spi_cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
        spi_sdi = frame[39 - i];
        #40;
        spi_sck = 1'b1;
        #40;
        spi_sck = 1'b0;
      end
      #40;
      spi_cs_n = 1'b1;
      // a released line shows the inverse, so a stale bit is never trusted
      spi_sdi = ~spi_sdi;
      // deselect gap well above the three system cycles the core needs
      #120;
    end
  endtask
endmodule

`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
  // ---------------------------------------------------------------
  // clock, reset and stimulus
  // ---------------------------------------------------------------
  localparam logic [39:0] we_frame = {flash_cmd_pkg::op_write_enable, 32'h0};
  localparam logic [39:0] wd_frame = {flash_cmd_pkg::op_write_disable, 32'h0};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic protection_lock_bit = 1'b0;
  logic array_verify_fail = 1'b0;
  logic [31:0] seed = 32'h50B6;
  wire spi_sck;
  wire spi_cs_n;
  wire spi_sdi;
  logic write_enable_latch;
  logic busy;
  logic err;
  logic go;
  logic exit_p;
  logic [31:0] prot;
  logic [7:0] fill;
  logic [23:0] first_a;
  logic [23:0] last_a;
  // reference model state
  logic exp_wel = 1'b0;
  logic [31:0] exp_prot = 32'hFFFFFFFF;
  int exp_go = 0;
  int exp_exit = 0;
  int go_seen = 0;
  int exit_seen = 0;
  int fail_count = 0;
  int samples_checked = 0;
  logic [7:0] ops [3];

  always #4 clk_sys = ~clk_sys;

  spi_host_model host_u (
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi)
  );

  // short erase counts keep any erase well inside the run
  erase_protect_ctrl #(.block_erase_cycles(20), .chip_erase_cycles(40)) dut_u (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi),
    .protection_lock_bit(protection_lock_bit),
    .array_verify_fail(array_verify_fail),
    .write_enable_latch_r(write_enable_latch),
    .busy_r(busy),
    .erase_program_error_flag_r(err),
    .sector_prot_r(prot),
    .erase_go_r(go),
    .erase_first_addr_r(first_a),
    .erase_last_addr_r(last_a),
    .erase_fill_r(fill),
    .seq_prog_exit_r(exit_p)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    begin
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      v = v ^ (v << 5);
      return v;
    end
  endfunction

  // random verify-fail noise; only matters while busy
  always @(negedge clk_sys) begin
    seed <= xs(seed);
    array_verify_fail <= seed[0];
  end

  // count one-cycle pulses
  always @(posedge clk_sys) begin
    if (go === 1'b1) begin
      go_seen++;
    end
    if (exit_p === 1'b1) begin
      exit_seen++;
    end
  end

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    begin
      samples_checked++;
      if (seen !== expd) begin
        fail_count++;
        $display("Error at %0t: seen %0h expected %0h", $time, seen, expd);
      end
    end
  endtask

  task automatic end_sim();
    begin
      if (fail_count == 0 && samples_checked > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask

  task automatic check_all();
    begin
      check({31'h0, write_enable_latch}, {31'h0, exp_wel});
      check(prot, exp_prot);
      check(go_seen, exp_go);
      check(exit_seen, exp_exit);
      check({31'h0, busy}, 32'h0);
      check({31'h0, err}, 32'h0);
      // no erase ever starts here, so the range keeps its reset value
      check({8'h0, first_a}, 32'h0);
      check({8'h0, last_a}, 32'h0);
    end
  endtask

  // send one frame, update the model, compare once the decision has landed
  task automatic run(input logic [39:0] frame, input int nbits, input logic lk);
    logic whole;
    logic [4:0] sec;
    begin
      whole = (nbits % 8 == 0);
      sec = frame[28:24];
      @(negedge clk_sys);
      protection_lock_bit = lk;
      host_u.send(frame, nbits);
      case (frame[39:32])
        flash_cmd_pkg::op_write_enable: if (whole) exp_wel = 1'b1;
        flash_cmd_pkg::op_write_disable: if (whole) begin
          exp_wel = 1'b0;
          exp_exit++;
        end
        flash_cmd_pkg::op_erase_4k, flash_cmd_pkg::op_erase_32k,
        flash_cmd_pkg::op_erase_64k: if (exp_wel) begin
          if (whole && nbits >= 32 && !exp_prot[sec]) exp_go++;
          exp_wel = 1'b0;
        end
        flash_cmd_pkg::op_chip_erase_a, flash_cmd_pkg::op_chip_erase_b: if (exp_wel && whole) begin
          if (exp_prot == 32'h0) exp_go++;
          exp_wel = 1'b0;
        end
        flash_cmd_pkg::op_protect_sector: if (exp_wel) begin
          if (whole && nbits >= 32 && !lk) exp_prot[sec] = 1'b1;
          exp_wel = 1'b0;
        end
        default: ;
      endcase
      @(negedge clk_sys);
      check_all();
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    ops[0] = flash_cmd_pkg::op_erase_4k;
    ops[1] = flash_cmd_pkg::op_erase_32k;
    ops[2] = flash_cmd_pkg::op_erase_64k;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    check_all();
    check({24'h0, fill}, {24'h0, flash_cmd_pkg::erased_byte});
    run(we_frame, 7, 1'b0);
    run({flash_cmd_pkg::op_erase_4k, seed[23:0], 8'h00}, 32, 1'b0);
    run(we_frame, 8, 1'b0);
    run({flash_cmd_pkg::op_erase_4k, 24'h012345, 8'h00}, 24, 1'b0);
    // every block size: 4k without trailing bytes, 32k and 64k with them
    for (int i = 0; i < 3; i++) begin
      run(we_frame, 8, 1'b0);
      run({ops[i], seed[23:0], 8'hA5}, 32 + 8 * i, 1'b0);
    end
    run(we_frame, 8, 1'b0);
    run({flash_cmd_pkg::op_chip_erase_a, 32'h0}, 12, 1'b0);
    run({flash_cmd_pkg::op_chip_erase_a, 32'h0}, 8, 1'b0);
    run(we_frame, 16, 1'b0);
    run({flash_cmd_pkg::op_chip_erase_b, 32'hDEADBEEF}, 24, 1'b0);
    run(we_frame, 8, 1'b0);
    run({flash_cmd_pkg::op_protect_sector, seed[23:0], 8'h00}, 32, 1'b1);
    run(we_frame, 8, 1'b0);
    run({flash_cmd_pkg::op_protect_sector, 24'h050000, 8'h00}, 20, 1'b0);
    run(we_frame, 8, 1'b0);
    run({flash_cmd_pkg::op_protect_sector, seed[23:0], 8'h3C}, 40, 1'b0);
    run(we_frame, 8, 1'b0);
    run(wd_frame, 9, 1'b0);
    run(wd_frame, 8, 1'b0);
    run({8'h9F, 32'h0}, 8, 1'b0);
    // reset in mid-run drops the latch and restores protection
    run(we_frame, 8, 1'b0);
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    exp_wel = 1'b0;
    exp_prot = 32'hFFFFFFFF;
    repeat (3) @(negedge clk_sys);
    check_all();
    // the first frame after a mid-run reset must still be taken
    run(we_frame, 8, 1'b0);
    end_sim();
  end

  // about 30 frames of at most 4 us each; the limit leaves ample margin
  initial begin
    #500000;
    fail_count++;
    end_sim();
  end
endmodule

`default_nettype wire
